// [hdl/osdcg_pkg.sv]
// Purpose: shared constants and types for the on-screen character generator
// Assumes: one system clock; display RAM laid out as 5 rows of 16 entries
// Notes: column 0 of each row holds that row's format character
package osdcg_pkg;
	// geometry
	localparam int ROWS = 5;
	localparam int COLS = 15;
	localparam int ROW_STRIDE = 16;
	localparam int RAM_DEPTH = 80;
	localparam int GLYPHS = 128;
	localparam int GLYPH_ROWS = 9;
	localparam int GLYPH_COLS = 6;
	// timing
	localparam int CLK_NS = 10;
	localparam int TDOT_NS = 20;
	localparam int TDOT_CLKS = (TDOT_NS + CLK_NS - 1) / CLK_NS;
	localparam int VSTART_STEP = 4;
	localparam int VGAP_STEP = 4;
	// core port map
	localparam logic [7:0] REG_VSTART = 8'h50;
	localparam logic [7:0] REG_HSTART = 8'h51;
	localparam logic [7:0] REG_VSPACE = 8'h52;
	localparam logic [7:0] REG_HSPACE = 8'h53;
	localparam logic [7:0] REG_BGCTL = 8'h54;
	localparam logic [7:0] REG_BANK = 8'h55;
	// display RAM entry fields
	localparam int ATTR_GAP = 0;
	localparam int ATTR_WE = 1;
	localparam int ATTR_BGS = 2;
	localparam int ATTR_SPACE = 6;
	localparam int FMT_SIZE = 6;
	// register fields
	localparam int VS_FRINGE = 6;
	localparam int HS_SIZE_LOW = 6;
	localparam int HS_SIZE_HIGH = 7;
	localparam int BG0_EN = 0;
	localparam int BG0_RGB = 1;
	localparam int BG1_EN = 4;
	localparam int BG1_RGB = 5;
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef struct packed {
		logic [2:0] rgb;
		logic bgs;
		logic we;
		logic gap;
	} osdcg_attr_t;

	typedef struct packed {
		logic [2:0] rgb;
		logic blank;
	} osdcg_pix_t;

	typedef enum logic [1:0] {V_IDLE, V_CHAR, V_GAP, V_DONE} osdcg_vstate_t;
	typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP, H_DONE} osdcg_hstate_t;
endpackage

// [hdl/osdcg_top.sv]
// Purpose: character overlay generator driving RGB and blanking from sync
// Assumes: sync inputs synchronous to CLK, active high, edge marks start
// Notes: glyph table is loadable through its own port instead of a mask

module osdcg_top (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// chassis sync
	input wire logic HSYNC,
	input wire logic VSYNC,
	// master enable, writable at any time
	input wire logic DISPLAY_MASTER_ENABLE,
	// core access to display RAM and layout registers
	input wire logic CORE_WE,
	input wire logic CORE_RE,
	input wire logic [7:0] CORE_ADDR,
	input wire logic [7:0] CORE_WDATA,
	output logic [7:0] CORE_RDATA,
	// glyph table load
	input wire logic GLYPH_WE,
	input wire logic [10:0] GLYPH_ADDR,
	input wire logic [5:0] GLYPH_WDATA,
	// picture outputs
	output logic RED,
	output logic GREEN,
	output logic BLUE,
	output logic BLANK
);
	logic [6:0] ram [0:osdcg_pkg::RAM_DEPTH-1];
	logic [5:0] glyph_mem [0:osdcg_pkg::GLYPHS-1][0:osdcg_pkg::GLYPH_ROWS-1];
	logic [7:0] vstart_q, hstart_q, vspace_q, hspace_q, bgctl_q;
	logic bank_q, bank_frame_q;
	logic hs_q, vs_q, hs_rise, vs_rise;
	logic [9:0] line_q;
	osdcg_pkg::osdcg_vstate_t vstate_q;
	osdcg_pkg::osdcg_hstate_t hstate_q;
	logic [2:0] row_q, vsub_q, vsub_last;
	logic [3:0] vdot_q, col_q;
	logic [7:0] vgap_q;
	logic [3:0] tdiv_q;
	logic tick;
	logic [6:0] hcnt_q;
	logic [1:0] hsub_q, hsub_last;
	logic [2:0] hdot_q;
	logic [5:0] hgap_q;
	osdcg_pkg::osdcg_attr_t attr_q;
	logic [6:0] fmt, cur;
	logic [2:0] mult;
	logic row_end;
	logic [5:0] glyph_row, fringe_row;
	logic [2:0] dot_idx;
	logic show, bg_en;
	logic [2:0] bg_rgb;
	osdcg_pkg::osdcg_pix_t pix;

	assign hs_rise = HSYNC & ~hs_q;
	assign vs_rise = VSYNC & ~vs_q;
	assign fmt = ram[{row_q, 4'h0}];
	// column 0 is never addressed while drawing
	assign cur = ram[{row_q, col_q}];

	// size code to dot scale; height 18*mult lines, width 6*mult dot units
	// line size bit joined with the global size pair
	always_comb
	begin
		unique case ({hspace_q[osdcg_pkg::HS_SIZE_HIGH], hspace_q[osdcg_pkg::HS_SIZE_LOW], fmt[osdcg_pkg::FMT_SIZE]})
			3'h0, 3'h2: mult = 3'h1;
			3'h1, 3'h4, 3'h6: mult = 3'h2;
			3'h3, 3'h5: mult = 3'h3;
			default: mult = 3'h4;
		endcase
	end
	// one dot is 2*mult lines tall and mult dot units wide
	assign vsub_last = 3'({mult, 1'b0} - 4'h1);
	assign hsub_last = 2'(mult - 3'h1);

	always_ff @(posedge CLK)
	begin
		hs_q <= RST_N & HSYNC;
		vs_q <= RST_N & VSYNC;
	end

	// layout registers and RAM only move while the display is off
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			vstart_q <= osdcg_pkg::REG_RESET;
			hstart_q <= osdcg_pkg::REG_RESET;
			vspace_q <= osdcg_pkg::REG_RESET;
			hspace_q <= osdcg_pkg::REG_RESET;
			bgctl_q <= osdcg_pkg::REG_RESET;
			bank_q <= 1'b0;
		end
		else if (CORE_WE && !DISPLAY_MASTER_ENABLE)
		begin
			case (CORE_ADDR)
				osdcg_pkg::REG_VSTART: vstart_q <= CORE_WDATA;
				osdcg_pkg::REG_HSTART: hstart_q <= CORE_WDATA;
				osdcg_pkg::REG_VSPACE: vspace_q <= CORE_WDATA;
				osdcg_pkg::REG_HSPACE: hspace_q <= CORE_WDATA;
				osdcg_pkg::REG_BGCTL: bgctl_q <= CORE_WDATA;
				osdcg_pkg::REG_BANK: bank_q <= CORE_WDATA[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (CORE_WE && !DISPLAY_MASTER_ENABLE && CORE_ADDR < 8'(osdcg_pkg::RAM_DEPTH))
			ram[CORE_ADDR[6:0]] <= CORE_WDATA[6:0];
		if (GLYPH_WE && GLYPH_ADDR[3:0] < 4'(osdcg_pkg::GLYPH_ROWS))
			glyph_mem[GLYPH_ADDR[10:4]][GLYPH_ADDR[3:0]] <= GLYPH_WDATA;
	end

	// reads answer zero while the display is on
	always_ff @(posedge CLK)
	begin
		if (!RST_N || !CORE_RE || DISPLAY_MASTER_ENABLE)
			CORE_RDATA <= 8'h00;
		else if (CORE_ADDR < 8'(osdcg_pkg::RAM_DEPTH))
			CORE_RDATA <= {1'b0, ram[CORE_ADDR[6:0]]};
		else
		begin
			case (CORE_ADDR)
				osdcg_pkg::REG_VSTART: CORE_RDATA <= vstart_q;
				osdcg_pkg::REG_HSTART: CORE_RDATA <= hstart_q;
				osdcg_pkg::REG_VSPACE: CORE_RDATA <= vspace_q;
				osdcg_pkg::REG_HSPACE: CORE_RDATA <= hspace_q;
				osdcg_pkg::REG_BGCTL: CORE_RDATA <= bgctl_q;
				osdcg_pkg::REG_BANK: CORE_RDATA <= {7'h00, bank_q};
				default: CORE_RDATA <= 8'h00;
			endcase
		end
	end

	// bank is frozen per frame so a screen never mixes banks
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			bank_frame_q <= 1'b0;
		else if (vs_rise)
			bank_frame_q <= bank_q;
	end

	// scan lines counted from vertical sync
	always_ff @(posedge CLK)
	begin
		if (!RST_N || vs_rise)
			line_q <= 10'h000;
		else if (hs_rise && line_q != 10'h3ff)
			line_q <= line_q + 10'h001;
	end

	assign row_end = vstate_q == osdcg_pkg::V_CHAR && vsub_q == vsub_last
		&& vdot_q == 4'(osdcg_pkg::GLYPH_ROWS - 1);

	// vertical walk through rows, one step per scan line
	always_ff @(posedge CLK)
	begin
		if (!RST_N || vs_rise)
		begin
			vstate_q <= osdcg_pkg::V_IDLE;
			row_q <= 3'h0;
			vsub_q <= 3'h0;
			vdot_q <= 4'h0;
			vgap_q <= 8'h00;
		end
		else if (hs_rise)
		begin
			unique case (vstate_q)
				osdcg_pkg::V_IDLE:
				begin
					// start line is four times the start field; zero is illegal and never starts
					if (vstart_q[5:0] != 6'h00 && line_q == {2'b00, vstart_q[5:0], 2'b00})
						vstate_q <= osdcg_pkg::V_CHAR;
				end
				osdcg_pkg::V_CHAR:
				begin
					vsub_q <= (vsub_q == vsub_last) ? 3'h0 : vsub_q + 3'h1;
					// glyph row restarts at every row end, also when a line gap follows
					if (vsub_q == vsub_last)
						vdot_q <= row_end ? 4'h0 : vdot_q + 4'h1;
					// gap of four lines per step only when the line asks for it
					if (row_end && fmt[osdcg_pkg::ATTR_GAP] && vspace_q[5:0] != 6'h00)
					begin
						vstate_q <= osdcg_pkg::V_GAP;
						vgap_q <= 8'({vspace_q[5:0], 2'b00} - 8'h01);
					end
					// next row follows directly, last row ends the screen
					else if (row_end)
					begin
						if (row_q == 3'(osdcg_pkg::ROWS - 1))
							vstate_q <= osdcg_pkg::V_DONE;
						else
							row_q <= row_q + 3'h1;
					end
				end
				osdcg_pkg::V_GAP:
				begin
					if (vgap_q != 8'h00)
						vgap_q <= vgap_q - 8'h01;
					else if (row_q == 3'(osdcg_pkg::ROWS - 1))
						vstate_q <= osdcg_pkg::V_DONE;
					else
					begin
						row_q <= row_q + 3'h1;
						vstate_q <= osdcg_pkg::V_CHAR;
					end
				end
				osdcg_pkg::V_DONE: ;
			endcase
		end
	end

	// dot unit divider, realigned on every line so columns do not drift
	assign tick = tdiv_q == 4'(osdcg_pkg::TDOT_CLKS - 1);
	always_ff @(posedge CLK)
	begin
		if (!RST_N || hs_rise || tick)
			tdiv_q <= 4'h0;
		else
			tdiv_q <= tdiv_q + 4'h1;
	end

	// horizontal walk through the cells of the current row
	always_ff @(posedge CLK)
	begin
		if (!RST_N || hs_rise)
		begin
			hstate_q <= osdcg_pkg::H_IDLE;
			hcnt_q <= 7'h00;
			col_q <= 4'h0;
			hsub_q <= 2'h0;
			hdot_q <= 3'h0;
			hgap_q <= 6'h00;
			attr_q <= '0;
		end
		else if (tick)
		begin
			unique case (hstate_q)
				osdcg_pkg::H_IDLE:
				begin
					// start after hstart dot units; format char sets first word
					if (vstate_q == osdcg_pkg::V_CHAR && hcnt_q == {1'b0, hstart_q[5:0]})
					begin
						hstate_q <= osdcg_pkg::H_RUN;
						col_q <= 4'h1;
						attr_q <= osdcg_pkg::osdcg_attr_t'(fmt[5:0]);
					end
					else if (hcnt_q != 7'h7f)
						hcnt_q <= hcnt_q + 7'h01;
				end
				osdcg_pkg::H_RUN:
				begin
					hsub_q <= (hsub_q == hsub_last) ? 2'h0 : hsub_q + 2'h1;
					if (hsub_q == hsub_last)
						hdot_q <= (hdot_q == 3'(osdcg_pkg::GLYPH_COLS - 1)) ? 3'h0 : hdot_q + 3'h1;
					if (hsub_q == hsub_last && hdot_q == 3'(osdcg_pkg::GLYPH_COLS - 1))
					begin
						// a space hands its attributes to the following word
						if (cur[osdcg_pkg::ATTR_SPACE])
							attr_q <= osdcg_pkg::osdcg_attr_t'(cur[5:0]);
						// extra gap of hgap+1 dot units after the six-dot space
						if (cur[osdcg_pkg::ATTR_SPACE] && cur[osdcg_pkg::ATTR_GAP])
						begin
							hstate_q <= osdcg_pkg::H_GAP;
							hgap_q <= hspace_q[5:0];
						end
						else if (col_q == 4'(osdcg_pkg::COLS))
							hstate_q <= osdcg_pkg::H_DONE;
						else
							col_q <= col_q + 4'h1;
					end
				end
				osdcg_pkg::H_GAP:
				begin
					if (hgap_q != 6'h00)
						hgap_q <= hgap_q - 6'h01;
					else if (col_q == 4'(osdcg_pkg::COLS))
						hstate_q <= osdcg_pkg::H_DONE;
					else
					begin
						col_q <= col_q + 4'h1;
						hstate_q <= osdcg_pkg::H_RUN;
					end
				end
				osdcg_pkg::H_DONE: ;
			endcase
		end
	end

	// pixel selection; glyph row bit 5 is the leftmost dot
	assign glyph_row = glyph_mem[{bank_frame_q, cur[5:0]}][vdot_q];
	assign fringe_row = ((glyph_row << 1) | (glyph_row >> 1)) & ~glyph_row;
	assign dot_idx = 3'(osdcg_pkg::GLYPH_COLS - 1) - hdot_q;
	// only display characters of enabled words on an enabled screen
	assign show = DISPLAY_MASTER_ENABLE && attr_q.we && !cur[osdcg_pkg::ATTR_SPACE]
		&& vstate_q == osdcg_pkg::V_CHAR && hstate_q == osdcg_pkg::H_RUN;
	// word chooses one of two backgrounds; fringe hugs the glyph sideways
	assign bg_en = attr_q.bgs ? bgctl_q[osdcg_pkg::BG1_EN] : bgctl_q[osdcg_pkg::BG0_EN];
	assign bg_rgb = attr_q.bgs ? bgctl_q[osdcg_pkg::BG1_RGB +: 3] : bgctl_q[osdcg_pkg::BG0_RGB +: 3];

	always_comb
	begin
		pix = '0;
		// glyph dots take the word colour and raise blanking
		if (show && glyph_row[dot_idx])
			pix = '{rgb: attr_q.rgb, blank: 1'b1};
		else if (show && bg_en && (!vstart_q[osdcg_pkg::VS_FRINGE] || fringe_row[dot_idx]))
			pix = '{rgb: bg_rgb, blank: 1'b1};
	end

	// registered outputs, colour bits are red, green, blue
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			{RED, GREEN, BLUE, BLANK} <= 4'h0;
		else
			{RED, GREEN, BLUE, BLANK} <= pix;
	end

	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	a_master_off_dark: assert property (!DISPLAY_MASTER_ENABLE |=> !BLANK)
		else $error("output active with master enable off");
	a_locked_read_zero: assert property (DISPLAY_MASTER_ENABLE && CORE_RE |=> CORE_RDATA == 8'h00)
		else $error("core read returned data while display on");
	a_locked_reg_write: assert property (DISPLAY_MASTER_ENABLE |=> $stable(hspace_q) && $stable(vstart_q))
		else $error("layout register changed while display on");
	a_format_not_drawn: assert property (hstate_q == osdcg_pkg::H_RUN |-> col_q != 4'h0 && col_q <= 4'h0f)
		else $error("format column reached the drawing path");
	a_row_bound: assert property (row_q < 3'(osdcg_pkg::ROWS))
		else $error("row index beyond grid");
	a_black_unblanked: assert property (!BLANK |-> !RED && !GREEN && !BLUE)
		else $error("colour output without blanking");
	a_dot_pace: assert property (tick && !hs_rise |=> !tick)
		else $error("dot unit shorter than two clocks");
	a_vstart_entry: assert property (vstate_q == osdcg_pkg::V_IDLE ##1 vstate_q == osdcg_pkg::V_CHAR
		|-> $past(line_q) == {2'b00, vstart_q[5:0], 2'b00})
		else $error("first row began on the wrong line");
	a_no_line_gap: assert property (hs_rise && row_end && !fmt[osdcg_pkg::ATTR_GAP] |=> vstate_q != osdcg_pkg::V_GAP)
		else $error("line gap inserted without enable");
	a_word_gap_cause: assert property (hstate_q == osdcg_pkg::H_RUN ##1 hstate_q == osdcg_pkg::H_GAP
		|-> $past(cur[osdcg_pkg::ATTR_SPACE] && cur[osdcg_pkg::ATTR_GAP]))
		else $error("word gap without gap-enabled space");

	c_glyph_dot: cover property (BLANK && $past(show));
	c_line_gap: cover property (vstate_q == osdcg_pkg::V_GAP);
	c_word_gap: cover property (hstate_q == osdcg_pkg::H_GAP);
	c_screen_done: cover property (vstate_q == osdcg_pkg::V_DONE);
endmodule

// [sim/osdcg_chassis.sv]
// Purpose: tv chassis stand-in that makes sync frames and watches the overlay
// Assumes: sync pulses active high, launched just after the clock edge
// Notes: lit cycles are counted and the colours seen while lit are folded
module osdcg_chassis #(
	parameter int LINE_CLKS = 400,
	parameter int LINES = 50
) (
	// clock
	input wire logic clk,
	// frame request and result
	input wire logic go,
	output logic busy,
	output int lit_cnt,
	output logic [2:0] rgb_or,
	output logic [2:0] rgb_and,
	// video link
	output logic hsync,
	output logic vsync,
	input wire logic red,
	input wire logic green,
	input wire logic blue,
	input wire logic blank
);
	timeunit 1ns;
	timeprecision 100ps;

	// one vertical edge, then one rising horizontal edge per line
	initial
	begin
		hsync = 1'h0;
		vsync = 1'h0;
		busy = 1'h0;
		forever
		begin
			@(posedge clk iff go);
			#1;
			busy = 1'h1;
			vsync = 1'h1;
			repeat (4) @(posedge clk);
			#1 vsync = 1'h0;
			repeat (LINES)
			begin
				hsync = 1'h1;
				repeat (4) @(posedge clk);
				#1 hsync = 1'h0;
				repeat (LINE_CLKS - 4) @(posedge clk);
				#1;
			end
			busy = 1'h0;
		end
	end

	// a cycle counts as lit only where blanking is driven high
	always @(posedge clk)
	begin
		if (go)
		begin
			lit_cnt <= 0;
			rgb_or <= 3'h0;
			rgb_and <= 3'h7;
		end
		else if (busy && blank === 1'h1)
		begin
			lit_cnt <= lit_cnt + 1;
			rgb_or <= rgb_or | {red, green, blue};
			rgb_and <= rgb_and & {red, green, blue};
		end
	end
endmodule

// [sim/tb_osd_character_display.sv]
// Purpose: self-checking bench for the character overlay generator
// Assumes: chassis model supplies sync; bench drives core and glyph ports
// Notes: expected values come from a byte model and the size table
module tb_osd_character_display;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, me, we, re, gwe, go, busy;
	logic [7:0] addr, wdata, rdata;
	logic [10:0] gaddr;
	logic [5:0] gdata;
	logic red, green, blue, blank, hsync, vsync;
	logic [2:0] rgb_or, rgb_and;
	int lit_cnt;
	int error_cnt = 0;
	int checks = 0;
	logic [7:0] mdl [int];
	// dot-unit multiple per size code {high, low, s}
	int mult [8] = '{1, 2, 1, 3, 2, 3, 2, 4};

	osdcg_top i_dut (
		.CLK(clk), .RST_N(rst_n), .HSYNC(hsync), .VSYNC(vsync), .DISPLAY_MASTER_ENABLE(me),
		.CORE_WE(we), .CORE_RE(re), .CORE_ADDR(addr), .CORE_WDATA(wdata), .CORE_RDATA(rdata),
		.GLYPH_WE(gwe), .GLYPH_ADDR(gaddr), .GLYPH_WDATA(gdata),
		.RED(red), .GREEN(green), .BLUE(blue), .BLANK(blank)
	);

	osdcg_chassis i_tv (
		.clk(clk), .go(go), .busy(busy), .lit_cnt(lit_cnt), .rgb_or(rgb_or), .rgb_and(rgb_and),
		.hsync(hsync), .vsync(vsync), .red(red), .green(green), .blue(blue), .blank(blank)
	);

	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_int(input int got, input int exp, input string what);
		checks++;
		if (got != exp)
		begin
			error_cnt++;
			$display("[ERR] %0t %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask

	// bits that each mapped place keeps; unmapped places keep nothing
	function automatic logic [7:0] mask(input logic [7:0] a);
		case (a)
			8'h50, 8'h51, 8'h52, 8'h53, 8'h54: return 8'hff;
			8'h55: return 8'h01;
			default: return (a < 8'h50) ? 8'h7f : 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (me !== 1'h0 || !mdl.exists(a))
			return 8'h00;
		return mdl[a];
	endfunction

	// an idle edge before each strobe keeps a driver from toggling twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		if (me === 1'h0 && a < 8'h56)
			mdl[a] = d & mask(a);
		addr = a;
		wdata = d;
		we = 1'h1;
		@(posedge clk);
		#1 we = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		#1;
		addr = a;
		re = 1'h1;
		@(posedge clk);
		#1 re = 1'h0;
		chk8(rdata, exp_rd(a), "core read");
	endtask

	task automatic glyph_fill();
		@(posedge clk);
		#1;
		gwe = 1'h1;
		for (int r = 0; r < 9; r++)
		begin
			gaddr = {7'h00, 4'(r)};
			gdata = 6'h3f;
			@(posedge clk);
			#1;
		end
		gwe = 1'h0;
	endtask

	task automatic frame();
		@(posedge clk);
		#1 go = 1'h1;
		@(posedge clk);
		#1 go = 1'h0;
		@(posedge clk);
		for (int n = 0; n < 30000 && busy === 1'h1; n++)
			@(posedge clk);
		#1;
		if (busy === 1'h1)
		begin
			error_cnt++;
			$display("[ERR] %0t frame did not end", $time);
		end
	endtask

	initial
	begin
		int m, ex;
		logic s;
		logic [2:0] col;
		logic [7:0] alist [10];
		alist = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'hff, 8'h00, 8'h4f};
		rst_n = 1'h0;
		me = 1'h0;
		we = 1'h0;
		re = 1'h0;
		addr = 8'h00;
		wdata = 8'h00;
		gwe = 1'h0;
		gaddr = 11'h000;
		gdata = 6'h00;
		go = 1'h0;
		void'($urandom(90));
		repeat (4) @(posedge clk);
		#1 rst_n = 1'h1;
		chk8({4'h0, red, green, blue, blank}, 8'h00, "outputs after reset");
		chk8(rdata, 8'h00, "read data after reset");
		$display("test reset done");

		alist[8] = 8'($urandom_range(1, 78));
		foreach (alist[i])
			wr(alist[i], 8'($urandom));
		foreach (alist[i])
			rd(alist[i]);
		me = 1'h1;
		wr(8'h51, 8'($urandom));
		rd(8'h51);
		rd(alist[8]);
		me = 1'h0;
		rd(8'h51);
		$display("test core access done");

		for (int a = 0; a < 80; a++)
			wr(8'(a), 8'h00);
		wr(8'h50, 8'h01);
		for (int a = 8'h51; a < 8'h56; a++)
			wr(8'(a), 8'h00);
		glyph_fill();
		// space before the third cell hides the rest of the row
		wr(8'h02, 8'h40);
		for (int k = 0; k < 3; k++)
		begin
			s = 1'($urandom_range(0, 1));
			col = 3'($urandom_range(0, 7));
			me = 1'h0;
			// format char opens row 0 with size, colour and word shown
			wr(8'h00, {1'h0, s, col, 3'h2});
			me = (k != 0);
			frame();
			m = mult[{2'h0, s}];
			ex = (k != 0) ? 216 * m * m : 0;
			chk_int(lit_cnt, ex, "lit cycles in frame");
			if (k != 0)
			begin
				chk8({5'h00, rgb_or}, {5'h00, col}, "colour seen, any");
				chk8({5'h00, rgb_and}, {5'h00, col}, "colour seen, all");
			end
			$display("test frame %0d done", k);
		end

		// line gap of 8 lines after row 0, word gap in row 1; row 1 must still be 18 lines tall
		col = 3'($urandom_range(0, 7));
		me = 1'h0;
		wr(8'h52, 8'h02);
		wr(8'h53, {2'h0, 6'($urandom)});
		wr(8'h00, {2'h0, col, 3'h3});
		wr(8'h10, {2'h0, col, 3'h2});
		wr(8'h12, {2'h1, col, 3'h3});
		me = 1'h1;
		frame();
		chk_int(lit_cnt, 216 * 15, "lit cycles with gaps");
		chk8({5'h00, rgb_or}, {5'h00, col}, "gap frame colour");
		chk8({5'h00, rgb_and}, {5'h00, col}, "gap frame colour, all");
		$display("test gap frame done");
		tally_and_finish();
	end

	// the four frames need about 81000 cycles
	initial
	begin
		#950000;
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
